// file: pkg/maac_pkg.sv
/*
  Constants for the memory alignment and atomicity checker.
  Assumes a 64-bit virtual address and byte-sized operand encodings.
*/
package maac_pkg;
  // ---------------------------------------------------------------
  // Operand sizes and geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 64;
  localparam logic [4:0] SZ_1           = 5'h01;
  localparam logic [4:0] SZ_2           = 5'h02;
  localparam logic [4:0] SZ_4           = 5'h04;
  localparam logic [4:0] SZ_8           = 5'h08;
  localparam logic [4:0] SZ_10          = 5'h0a;
  localparam logic [4:0] SZ_16          = 5'h10;
  localparam logic [5:0] SZ_32          = 6'h20;
  localparam logic [5:0] ALIGN_EXT      = 6'h10;
  localparam logic [12:0] PAGE_4K       = 13'h1000;
  localparam int unsigned LINE_BYTES    = 64;
  localparam logic [5:0] TBL_ENTRY_BYTES = 6'h08;
  // ---------------------------------------------------------------
  // Reference kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    REF_LOAD, REF_STORE, REF_SEMA, REF_FETCH, REF_WALK, REF_ADV_LOAD,
    REF_PAIR_LOAD
  } maac_kind_e;
  // Reset values
  localparam logic RST_BUSY = 1'b0;
endpackage : maac_pkg

// file: hw/maac_top.sv
/*
  Alignment and atomicity checker for one load/store issue slot.
  Assumes a single-issue request stream; results one cycle later.
*/
`timescale 1ns/1ps
// What this block does
// - Fetches and aligned references are atomic except extended to non-WB memory
// - Aligned extended reference to non-WB memory may raise unsupported fault
// - Loads may forward from store buffer; result may look non-atomic
// - 16-byte aligned integer or double pair is one atomic access
// - 8-byte aligned single pair is one atomic access
// - Aligned references never raise the unaligned fault
// - An instruction is fetched atomically with its bundle template
// - With check enabled, misaligned native references fault and are suppressed
// - Sizes align on own size; 10 and 16 byte on 16
// - With check enabled, misaligned legacy references raise legacy exception
// - Page walker table entries are always 32-byte aligned
// - Misaligned native semaphore references always fault
// - With check off, native cache line crossing faults by choice
// - Native reference crossing a 4K boundary always faults
// - Legacy references never fault when both checks are off
// - With check off, unaligned advanced loads execute; table allocation may be declined
// - Unaligned advanced load may allocate a larger covering entry
// - Any store may invalidate entries from unaligned loads
// - Faults reported precisely, in order, one reference at a time
// - State saved on fault and restored on return
module maac_top
  import maac_pkg::*;
#(
  parameter int unsigned LINE_B = maac_pkg::LINE_BYTES
)(
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      SRST_I,
  input  wire logic                      REQ_VALID_I,
  input  wire logic [2:0]                REQ_KIND_I,
  input  wire logic [4:0]                REQ_SIZE_I,
  input  wire logic [maac_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input  wire logic                      REQ_LEGACY_I,
  input  wire logic                      REQ_WB_I,
  input  wire logic                      ALIGNMENT_CHECK_ENABLE_I,
  input  wire logic                      LEGACY_CHECK_EN_I,
  input  wire logic                      EXT_UNSUP_EN_I,
  input  wire logic                      STBUF_HIT_I,
  input  wire logic                      RFI_I,
  output logic                           MEM_REQ_O,
  output logic [maac_pkg::ADDR_W-1:0]    MEM_ADDR_O,
  output logic [5:0]                     MEM_BYTES_O,
  output logic                           MEM_ATOMIC_O,
  output logic                           MEM_FWD_O,
  output logic                           UNALIGNED_FAULT_O,
  output logic                           LEGACY_AC_FAULT_O,
  output logic                           UNSUP_FAULT_O,
  output logic                           TBL_ALLOC_O,
  output logic [maac_pkg::ADDR_W-1:0]    TBL_ADDR_O,
  output logic [5:0]                     TBL_BYTES_O,
  output logic                           TBL_INV_UNALIGNED_O,
  output logic                           FAULT_PENDING_O,
  output logic [maac_pkg::ADDR_W-1:0]    SAVED_ADDR_O,
  output logic                           RESUME_O
);
  import maac_pkg::*;

  // Fault state is read by the decode below, so it is declared first
  logic              fault_pend_r;
  logic [ADDR_W-1:0] saved_r;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic [5:0] align_of(input logic [4:0] sz,
                                          input logic [2:0] kd);
    if (kd == REF_WALK)
      align_of = SZ_32;
    else if (sz == SZ_10 || sz == SZ_16)
      align_of = ALIGN_EXT;
    else if (kd == REF_PAIR_LOAD && sz == SZ_16)
      align_of = ALIGN_EXT;
    else
      align_of = {1'b0, sz};
  endfunction : align_of

  wire logic [5:0]  req_align = align_of(REQ_SIZE_I, REQ_KIND_I);
  wire logic [5:0]  low_bits  = REQ_ADDR_I[5:0];
  wire logic [5:0]  align_msk = req_align - 6'h01;
  wire logic        misalign  = |(low_bits & align_msk);
  wire logic [12:0] span_end  = {1'b0, REQ_ADDR_I[11:0]}
                                + {8'h00, REQ_SIZE_I} - 13'h0001;
  wire logic        cross_4k  = span_end[12];
  wire logic [6:0]  line_end  = {1'b0, REQ_ADDR_I[5:0]}
                                + {2'h0, REQ_SIZE_I} - 7'h01;
  wire logic        cross_ln  = (LINE_B == 64) ? line_end[6] : 1'b0;
  wire logic        is_fetch  = REQ_KIND_I == REF_FETCH;
  wire logic        is_sema   = REQ_KIND_I == REF_SEMA;
  wire logic        is_store  = REQ_KIND_I == REF_STORE;
  wire logic        is_adv    = REQ_KIND_I == REF_ADV_LOAD;
  wire logic        is_data   = !is_fetch;
  wire logic        active    = REQ_VALID_I && !fault_pend_r;

  // Native faults; aligned references never get here
  wire logic nat_fault = active && is_data && !REQ_LEGACY_I && misalign
    && (ALIGNMENT_CHECK_ENABLE_I
        || is_sema
        || cross_ln);
  wire logic nat_4k = active && is_data && !REQ_LEGACY_I
    && cross_4k;
  wire logic unal_f = nat_fault || nat_4k;
  wire logic leg_f  = active && is_data && REQ_LEGACY_I && misalign
    && (ALIGNMENT_CHECK_ENABLE_I || LEGACY_CHECK_EN_I);
  // Optional unsupported fault for extended non-WB references
  wire logic uns_f  = active && !misalign && !REQ_LEGACY_I && EXT_UNSUP_EN_I
    && REQ_SIZE_I == SZ_10 && !REQ_WB_I;
  wire logic any_f  = unal_f || leg_f || uns_f;
  wire logic issue  = active && !any_f;
  // Atomic when aligned, except extended to non-WB memory or a store buffer hit
  wire logic atomic = !misalign && !(REQ_SIZE_I == SZ_10 && !REQ_WB_I)
    && !STBUF_HIT_I;
  // Fetches move a whole bundle with its template in one access
  wire logic [5:0] bytes = is_fetch ? ALIGN_EXT
                         : {1'b0, REQ_SIZE_I};
  // Covering entry: round down to an 8-byte boundary, one or two 8-byte blocks
  wire logic        tbl_wide = is_adv && misalign;
  wire logic [ADDR_W-1:0] tbl_base = tbl_wide
    ? {REQ_ADDR_I[ADDR_W-1:3], 3'h0} : REQ_ADDR_I;
  wire logic [6:0]  tbl_need = {1'b0, REQ_ADDR_I[2:0] == 3'h0 ? 6'h00
    : {3'h0, REQ_ADDR_I[2:0]}} + {2'h0, REQ_SIZE_I};
  wire logic [5:0]  tbl_sz = !tbl_wide ? {1'b0, REQ_SIZE_I}
    : (tbl_need > 7'h08) ? ALIGN_EXT : TBL_ENTRY_BYTES;
  // Wide entries that would not cover the range are declined
  wire logic tbl_ok = !tbl_wide || tbl_need <= 7'h10;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      MEM_REQ_O           <= 1'b0;
      MEM_ADDR_O          <= '0;
      MEM_BYTES_O         <= 6'h00;
      MEM_ATOMIC_O        <= 1'b0;
      MEM_FWD_O           <= 1'b0;
      UNALIGNED_FAULT_O   <= 1'b0;
      LEGACY_AC_FAULT_O   <= 1'b0;
      UNSUP_FAULT_O       <= 1'b0;
      TBL_ALLOC_O         <= 1'b0;
      TBL_ADDR_O          <= '0;
      TBL_BYTES_O         <= 6'h00;
      TBL_INV_UNALIGNED_O <= 1'b0;
      RESUME_O            <= 1'b0;
    end
    else
    begin
      MEM_REQ_O           <= issue;
      MEM_ADDR_O          <= REQ_ADDR_I;
      MEM_BYTES_O         <= bytes;
      MEM_ATOMIC_O        <= issue && atomic;
      MEM_FWD_O           <= issue && STBUF_HIT_I
                             && !is_store;
      UNALIGNED_FAULT_O   <= unal_f;
      LEGACY_AC_FAULT_O   <= leg_f;
      UNSUP_FAULT_O       <= uns_f;
      TBL_ALLOC_O         <= issue && is_adv && tbl_ok;
      TBL_ADDR_O          <= tbl_base;
      TBL_BYTES_O         <= tbl_sz;
      TBL_INV_UNALIGNED_O <= issue && is_store;
      RESUME_O            <= fault_pend_r && RFI_I;
    end
  end

  // Fault holds off later references until return, keeping order precise
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      fault_pend_r <= RST_BUSY;
      saved_r      <= '0;
    end
    else if (any_f)
    begin
      fault_pend_r <= 1'b1;
      saved_r      <= REQ_ADDR_I;
    end
    else if (RFI_I)
      fault_pend_r <= 1'b0;
  end

  assign FAULT_PENDING_O = fault_pend_r;
  assign SAVED_ADDR_O    = saved_r;
endmodule : maac_top

// file: tb/maac_stbuf_model.sv
/*
  Store buffer stand-in for the memory side of the checker.
  Assumes requests qualified by the bench's valid strobe.
*/
`timescale 1ns/1ps
module maac_stbuf_model
  import maac_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        vld_i,
  input  wire logic [2:0]  kind_i,
  input  wire logic [63:0] addr_i,
  output logic             hit_o
);
  logic [63:0] last_r;
  logic        full_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      full_r <= 1'h0;
    else if (vld_i && kind_i == REF_STORE)
    begin
      full_r <= 1'h1;
      last_r <= addr_i;
    end
  end
  // Exact match only; partial overlaps go to memory
  assign hit_o = vld_i && full_r && kind_i == REF_LOAD && addr_i == last_r;
endmodule : maac_stbuf_model

// file: tb/maac_properties.sv
/*
  Port-level properties of the alignment checker.
  Assumes binding to maac_top; answers land one cycle after a request.
*/
`timescale 1ns/1ps
module maac_properties
  import maac_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        SRST_I,
  input wire logic        REQ_VALID_I,
  input wire logic [2:0]  REQ_KIND_I,
  input wire logic [4:0]  REQ_SIZE_I,
  input wire logic [63:0] REQ_ADDR_I,
  input wire logic        REQ_LEGACY_I,
  input wire logic        REQ_WB_I,
  input wire logic        ALIGNMENT_CHECK_ENABLE_I,
  input wire logic        EXT_UNSUP_EN_I,
  input wire logic        RFI_I,
  input wire logic        MEM_REQ_O,
  input wire logic        UNALIGNED_FAULT_O,
  input wire logic        LEGACY_AC_FAULT_O,
  input wire logic        UNSUP_FAULT_O,
  input wire logic        FAULT_PENDING_O,
  input wire logic [63:0] SAVED_ADDR_O,
  input wire logic        RESUME_O
);
  // 10 and 16 byte data share the 16 byte boundary
  wire logic [4:0] msk = (REQ_SIZE_I > 5'h08) ? 5'h0f : REQ_SIZE_I - 5'h01;
  wire logic mis = |(REQ_ADDR_I[4:0] & msk);
  wire logic tk = REQ_VALID_I & ~FAULT_PENDING_O;
  wire logic nat = tk & ~REQ_LEGACY_I & (REQ_KIND_I <= 3'h2);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  ac_fault_a: assert property (nat & ALIGNMENT_CHECK_ENABLE_I & mis |=>
    UNALIGNED_FAULT_O & ~MEM_REQ_O & SAVED_ADDR_O == $past(REQ_ADDR_I))
    else $error("misaligned reference not faulted");
  aligned_ok_a: assert property (nat & ~mis |=> ~UNALIGNED_FAULT_O)
    else $error("aligned reference faulted");
  sema_fault_a: assert property (nat & REQ_KIND_I == REF_SEMA & mis
    |=> UNALIGNED_FAULT_O) else $error("semaphore misalign missed");
  legacy_ac_a: assert property (tk & REQ_LEGACY_I & ALIGNMENT_CHECK_ENABLE_I
    & REQ_KIND_I != REF_FETCH & mis |=> LEGACY_AC_FAULT_O)
    else $error("legacy fault missed");
  page_cross_a: assert property (nat & (REQ_ADDR_I[11:0] + REQ_SIZE_I
    > 13'h1000) |=> UNALIGNED_FAULT_O) else $error("page cross missed");
  unsup_ext_a: assert property (nat & REQ_SIZE_I == SZ_10 & ~REQ_WB_I
    & EXT_UNSUP_EN_I & ~mis |=> UNSUP_FAULT_O & ~MEM_REQ_O)
    else $error("unsupported fault missed");
  resume_a: assert property (FAULT_PENDING_O & RFI_I |=>
    RESUME_O & ~FAULT_PENDING_O) else $error("return not taken");
  refused_a: assert property (REQ_VALID_I & FAULT_PENDING_O & ~RFI_I |=>
    ~MEM_REQ_O & FAULT_PENDING_O) else $error("request taken while pending");
endmodule : maac_properties
bind maac_top maac_properties u_chk (.*);

// file: tb/tb_top.sv
/*
  Self-checking bench for the alignment checker.
  Assumes one-cycle answers and faults held until a return.
*/
`timescale 1ns/1ps
module tb_top;
  import maac_pkg::*;
  logic clk = 0, rst = 1, vld = 0, leg = 0, wb = 1, ac = 0, une = 0, rfi = 0;
  logic lce = 0;
  wire [63:0] maddr;
  logic [2:0] knd = 0;
  logic [4:0] sz = 1;
  logic [63:0] adr = 0;
  logic [4:0] szs [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h10};
  wire hit, mreq, atom, fwd, unal, lacf, unsf, talc, tinv, pend, resm;
  wire [63:0] saved, taddr;
  wire [5:0] mby, tby;
  int fails = 0, samples_checked = 0;
  initial forever #4 clk = ~clk;
  maac_stbuf_model u_mem (.clk_i(clk), .rst_i(rst), .vld_i(vld),
    .kind_i(knd), .addr_i(adr), .hit_o(hit));
  maac_top dut (.CORE_CLK_I(clk), .SRST_I(rst), .REQ_VALID_I(vld),
    .REQ_KIND_I(knd), .REQ_SIZE_I(sz), .REQ_ADDR_I(adr), .REQ_LEGACY_I(leg),
    .REQ_WB_I(wb), .ALIGNMENT_CHECK_ENABLE_I(ac), .LEGACY_CHECK_EN_I(lce),
    .EXT_UNSUP_EN_I(une), .STBUF_HIT_I(hit), .RFI_I(rfi), .MEM_REQ_O(mreq),
    .MEM_ADDR_O(maddr), .MEM_BYTES_O(mby), .MEM_ATOMIC_O(atom), .MEM_FWD_O(fwd),
    .UNALIGNED_FAULT_O(unal), .LEGACY_AC_FAULT_O(lacf), .UNSUP_FAULT_O(unsf),
    .TBL_ALLOC_O(talc), .TBL_ADDR_O(taddr), .TBL_BYTES_O(tby),
    .TBL_INV_UNALIGNED_O(tinv), .FAULT_PENDING_O(pend),
    .SAVED_ADDR_O(saved), .RESUME_O(resm));
  task chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task conclude;
    $display("mismatches %0d checks %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Issue one request; on a fault, try a refused one, then return
  task go(input [2:0] k, input [4:0] s, input [63:0] a, input [2:0] f);
    @(posedge clk); knd <= k; sz <= s; adr <= a; vld <= 1;
    @(posedge clk); vld <= 0; adr <= 0;
    #1 chk(mreq, f == 0);
    chk({unal, lacf, unsf}, f);
    if (f != 0)
    begin
      chk(saved, a);
      @(posedge clk); vld <= 1;
      @(posedge clk); vld <= 0; rfi <= 1;
      #1 chk(mreq, 0);
      @(posedge clk); rfi <= 0;
      #1 chk(resm, 1);
      chk(pend, 0);
    end
  endtask : go
  task t_ac;
    ac <= 1;
    go(REF_WALK, 8, 64'h810, 3'h4);
    go(REF_WALK, 8, 64'h820, 0);
    for (int i = 0; i < 6; i++)
    begin
      go(REF_LOAD, szs[i], 64'h100, 0);
      if (i > 0) go(REF_STORE, szs[i], 64'h100 + szs[i] / 2, 3'h4);
    end
    ac <= 0;
  endtask : t_ac
  task t_off;
    go(REF_SEMA, 8, 64'h204, 3'h4);
    go(REF_LOAD, 4, 64'h201, 0);
    go(REF_LOAD, 8, 64'h23c, 3'h4);
    go(REF_LOAD, 8, 64'hffc, 3'h4);
    leg <= 1;
    go(REF_LOAD, 8, 64'hffc, 0);
    lce <= 1;
    go(REF_LOAD, 4, 64'h302, 3'h2);
    lce <= 0;
    ac <= 1;
    go(REF_LOAD, 4, 64'h302, 3'h2);
    ac <= 0;
    leg <= 0;
  endtask : t_off
  task t_mem;
    wb <= 0;
    une <= 1;
    go(REF_LOAD, 10, 64'h400, 3'h1);
    une <= 0;
    go(REF_LOAD, 10, 64'h400, 0); chk(atom, 0);
    wb <= 1;
    go(REF_PAIR_LOAD, 16, 64'h510, 0); chk(atom, 1); chk(mby, 16);
    go(REF_PAIR_LOAD, 8, 64'h508, 0); chk(atom, 1); chk(mby, 8);
    go(REF_FETCH, 16, 64'h700, 0); chk(atom, 1); chk(mby, 16);
    go(REF_ADV_LOAD, 4, 64'h3, 0); chk(talc, 1);
    chk(taddr, 0); chk(tby, 8);
    go(REF_STORE, 8, 64'h600, 0); chk(tinv, 1);
    go(REF_LOAD, 8, 64'h600, 0); chk(fwd, 1); chk(atom, 0);
    chk(maddr, 64'h600);
  endtask : t_mem
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_ac;
    t_off;
    t_mem;
    conclude;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    conclude;
  end
endmodule : tb_top
